// *** hdl/power_enable_fault_sequencer.sv ***
`timescale 1ns/1ps

module power_enable_fault_sequencer #(
  parameter int OSC_DIV = power_seq_pkg::OSC_DIV,
  parameter int EN_TICKS = power_seq_pkg::EN_DEGLITCH_TICKS,
  parameter int VIO_TICKS = power_seq_pkg::VIO_SD_TICKS,
  parameter int TEMP_TICKS = power_seq_pkg::TEMP_TICKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire power_seq_pkg::supply_status_type supply,
  input wire logic fault_detect,
  input wire logic temp_warning_raw,
  input wire logic temp_shutdown_raw,
  input wire logic enable_latch_hold_clear,
  input wire logic io_supply_uv_fault_clear,
  input wire logic enable_fault_pin_in,
  output logic enable_fault_pin_out,
  output logic enable_fault_pin_oe_n,
  output logic rails_on,
  output power_seq_pkg::seq_state_type power_state,
  output power_seq_pkg::seq_status_type status
);

  // ****************************************************************
  // Timing base and filters
  // ****************************************************************
  logic tick;
  logic vio_sd_filtered;
  logic [1:0] temp_raw;
  logic [1:0] temp_filtered;

  osc_tick #(
    .DIV(OSC_DIV)
  ) u_osc_tick (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  deglitch_filter #(
    .TICKS(VIO_TICKS)
  ) u_vio_filter (
    .clock(clock),
    .rst(rst),
    .tick(tick),
    .raw(supply.io_supply_sd),
    .filtered(vio_sd_filtered)
  );

  assign temp_raw = {temp_shutdown_raw, temp_warning_raw};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_temp
      deglitch_filter #(
        .TICKS(TEMP_TICKS)
      ) u_temp_filter (
        .clock(clock),
        .rst(rst),
        .tick(tick),
        .raw(temp_raw[i]),
        .filtered(temp_filtered[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  power_seq_pkg::seq_regs_type r_reg;
  power_seq_pkg::seq_regs_type r_next;

  logic start_ok;
  logic pin_low;
  logic serial_running;
  logic io_shutdown;

  assign start_ok = enable_fault_pin_in && supply.vin_above_on && !supply.vin_below_off &&
                    (supply.io_supply_high || supply.io_supply_grounded);
  assign pin_low = !enable_fault_pin_in || !r_reg.pin_oe_n;
  assign serial_running = (r_reg.state == power_seq_pkg::SEQ_RUN_LATCHED) ||
                          (r_reg.state == power_seq_pkg::SEQ_RUN_UNLATCHED);
  // The filtered level is only meaningful in serial mode: a grounded supply
  // in stand-alone mode would otherwise look like a permanent shutdown.
  assign io_shutdown = vio_sd_filtered && r_reg.serial && (r_reg.state != power_seq_pkg::SEQ_OFF);

  always_comb begin
    r_next = r_reg;
    case (r_reg.state)
      power_seq_pkg::SEQ_OFF: begin
        r_next.rails = 1'b0;
        r_next.latch = 1'b0;
        r_next.pin_oe_n = 1'b1;
        r_next.en_count = '0;
        if (start_ok) begin
          r_next.state = power_seq_pkg::SEQ_POWER_UP;
          r_next.serial = supply.io_supply_high;
        end
      end
      power_seq_pkg::SEQ_POWER_UP: begin
        if (!enable_fault_pin_in) begin
          r_next.state = power_seq_pkg::SEQ_OFF;
        end else if (tick) begin
          if (r_reg.en_count == power_seq_pkg::EN_COUNT_W'(EN_TICKS - 1)) begin
            r_next.rails = 1'b1;
            if (r_reg.serial) begin
              r_next.state = power_seq_pkg::SEQ_RUN_LATCHED;
              r_next.latch = 1'b1;
            end else begin
              r_next.state = power_seq_pkg::SEQ_RUN_STANDALONE;
            end
          end else begin
            r_next.en_count = r_reg.en_count + power_seq_pkg::EN_COUNT_W'(1);
          end
        end
      end
      power_seq_pkg::SEQ_RUN_STANDALONE: begin
        if (!enable_fault_pin_in) begin
          r_next.state = power_seq_pkg::SEQ_OFF;
        end
      end
      power_seq_pkg::SEQ_RUN_LATCHED: begin
        r_next.pin_oe_n = !fault_detect;
        if (enable_latch_hold_clear) begin
          r_next.state = power_seq_pkg::SEQ_RUN_UNLATCHED;
          r_next.latch = 1'b0;
        end
      end
      power_seq_pkg::SEQ_RUN_UNLATCHED: begin
        r_next.pin_oe_n = !fault_detect;
        if (pin_low) begin
          r_next.state = power_seq_pkg::SEQ_OFF;
          r_next.pin_oe_n = 1'b1;
          r_next.rails = 1'b0;
        end
      end
      default: begin
        r_next.state = power_seq_pkg::SEQ_OFF;
      end
    endcase

    // A new undervoltage report wins over a clear in the same cycle.
    r_next.uv_fault = (r_reg.uv_fault && !io_supply_uv_fault_clear) ||
                      (serial_running && supply.io_supply_uv);

    if (io_shutdown) begin
      r_next.state = power_seq_pkg::SEQ_OFF;
      r_next.latch = 1'b0;
      r_next.pin_oe_n = 1'b1;
      r_next.rails = 1'b0;
    end
    if (supply.vin_below_off) begin
      r_next.state = power_seq_pkg::SEQ_OFF;
      r_next.rails = 1'b0;
      r_next.latch = 1'b0;
      r_next.pin_oe_n = 1'b1;
    end
    if (r_next.state == power_seq_pkg::SEQ_OFF) begin
      r_next.rails = 1'b0;
      r_next.pin_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg.state <= power_seq_pkg::SEQ_OFF;
      r_reg.serial <= 1'b0;
      r_reg.latch <= power_seq_pkg::RESET_LATCH;
      r_reg.pin_oe_n <= power_seq_pkg::RESET_PIN_OE_N;
      r_reg.rails <= power_seq_pkg::RESET_RAILS;
      r_reg.uv_fault <= 1'b0;
      r_reg.en_count <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The pin is open drain: it is only ever pulled low, never driven high.
  assign enable_fault_pin_out = 1'b0;
  assign enable_fault_pin_oe_n = r_reg.pin_oe_n;
  assign rails_on = r_reg.rails;
  assign power_state = r_reg.state;
  assign status.temp_warning = temp_filtered[0];
  assign status.temp_shutdown = temp_filtered[1];
  assign status.io_supply_uv_fault = r_reg.uv_fault;
  assign status.enable_latch_hold = r_reg.latch;
  assign status.serial_mode = r_reg.serial;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic [15:0] sd_held;
  always_ff @(posedge clock) begin
    if (rst || !supply.io_supply_sd) begin
      sd_held <= '0;
    end else if (sd_held != 16'hffff) begin
      sd_held <= sd_held + 16'h0001;
    end
  end

  sequence s_serial_start;
    r_reg.state == power_seq_pkg::SEQ_POWER_UP ##1 r_reg.state == power_seq_pkg::SEQ_RUN_LATCHED;
  endsequence

  sequence s_unlatch;
    r_reg.state == power_seq_pkg::SEQ_RUN_LATCHED && enable_latch_hold_clear &&
    !supply.vin_below_off && !io_shutdown;
  endsequence

  property p_start_cond;
    (r_reg.state == power_seq_pkg::SEQ_OFF ##1 r_reg.state == power_seq_pkg::SEQ_POWER_UP) |->
      $past(start_ok);
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("power-up began without conditions");

  property p_abort;
    (r_reg.state == power_seq_pkg::SEQ_POWER_UP && !enable_fault_pin_in) |=>
      r_reg.state == power_seq_pkg::SEQ_OFF && !rails_on;
  endproperty
  a_abort: assert property (p_abort) else $error("enable drop did not abort power-up");

  property p_standalone;
    (r_reg.state == power_seq_pkg::SEQ_RUN_STANDALONE |-> !status.enable_latch_hold) and
    (r_reg.state == power_seq_pkg::SEQ_RUN_STANDALONE && !enable_fault_pin_in |=>
      r_reg.state == power_seq_pkg::SEQ_OFF);
  endproperty
  a_standalone: assert property (p_standalone) else $error("stand-alone enable handling wrong");

  property p_latch;
    s_serial_start |-> status.enable_latch_hold && rails_on && enable_fault_pin_oe_n;
  endproperty
  a_latch: assert property (p_latch) else $error("serial start did not latch enable");

  property p_fault_pull;
    (serial_running && fault_detect && !supply.vin_below_off && !io_shutdown && !pin_low) |=>
      !enable_fault_pin_oe_n;
  endproperty
  a_fault_pull: assert property (p_fault_pull) else $error("fault did not pull pin low");

  property p_lockout;
    supply.vin_below_off |=> r_reg.state == power_seq_pkg::SEQ_OFF && !rails_on && enable_fault_pin_oe_n;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout did not shut down");

  property p_unlatch;
    s_unlatch |=> r_reg.state == power_seq_pkg::SEQ_RUN_UNLATCHED && !status.enable_latch_hold;
  endproperty
  a_unlatch: assert property (p_unlatch) else $error("latch clear not taken");

  property p_self_fault_off;
    (r_reg.state == power_seq_pkg::SEQ_RUN_UNLATCHED && !enable_fault_pin_oe_n) |=>
      r_reg.state == power_seq_pkg::SEQ_OFF;
  endproperty
  a_self_fault_off: assert property (p_self_fault_off) else $error("own pulldown did not shut down");

  property p_uv_flag;
    (serial_running && supply.io_supply_uv && !supply.vin_below_off && !io_shutdown &&
     r_reg.state == power_seq_pkg::SEQ_RUN_LATCHED && !enable_latch_hold_clear) |=>
      status.io_supply_uv_fault && r_reg.state == power_seq_pkg::SEQ_RUN_LATCHED;
  endproperty
  a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag wrong");

  property p_io_shutdown;
    io_shutdown |=> r_reg.state == power_seq_pkg::SEQ_OFF && enable_fault_pin_oe_n && !status.enable_latch_hold;
  endproperty
  a_io_shutdown: assert property (p_io_shutdown) else $error("I/O shutdown not handled");

  property p_io_filter;
    $rose(vio_sd_filtered) |-> sd_held >= 16'((VIO_TICKS - 1) * OSC_DIV);
  endproperty
  a_io_filter: assert property (p_io_filter) else $error("I/O shutdown filter too short");

endmodule

// *** include/power_seq_pkg.sv ***
package power_seq_pkg;

  // ****************************************************************
  // Clock and oscillator timing
  // ****************************************************************
  localparam int CLOCK_KHZ = 125000;
  localparam int OSC_KHZ = 8000;
  localparam int OSC_MIN_KHZ = 7000;
  localparam int OSC_MAX_KHZ = 9000;
  // Oscillator ticks are made by dividing the system clock, rounded down.
  localparam int OSC_DIV = CLOCK_KHZ / OSC_KHZ;

  // ****************************************************************
  // Filter times, in microseconds and in oscillator ticks
  // ****************************************************************
  localparam int VIO_SD_US = 100;
  localparam int VIO_SD_MIN_US = 80;
  localparam int VIO_SD_MAX_US = 120;
  localparam int VIO_SD_TICKS = VIO_SD_US * OSC_KHZ / 1000;
  localparam int TEMP_DELAY_US = 12;
  localparam int TEMP_TICKS = TEMP_DELAY_US * OSC_KHZ / 1000;
  localparam int EN_DEGLITCH_TICKS = 64;
  localparam int EN_COUNT_W = 16;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RESET_LATCH = 1'b0;
  localparam logic RESET_PIN_OE_N = 1'b1;
  localparam logic RESET_RAILS = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SEQ_OFF = 3'h0,
    SEQ_POWER_UP = 3'h1,
    SEQ_RUN_STANDALONE = 3'h2,
    SEQ_RUN_LATCHED = 3'h3,
    SEQ_RUN_UNLATCHED = 3'h4
  } seq_state_type;

  typedef struct packed {
    logic vin_above_on;
    logic vin_below_off;
    logic io_supply_high;
    logic io_supply_grounded;
    logic io_supply_uv;
    logic io_supply_sd;
  } supply_status_type;

  typedef struct packed {
    logic temp_warning;
    logic temp_shutdown;
    logic io_supply_uv_fault;
    logic enable_latch_hold;
    logic serial_mode;
  } seq_status_type;

  typedef struct packed {
    seq_state_type state;
    logic serial;
    logic latch;
    logic pin_oe_n;
    logic rails;
    logic uv_fault;
    logic [EN_COUNT_W-1:0] en_count;
  } seq_regs_type;

endpackage

// *** hdl/osc_tick.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Oscillator tick divider
// ****************************************************************
module osc_tick #(
  parameter int DIV = power_seq_pkg::OSC_DIV
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [W-1:0] count;
    logic tick;
  } tick_regs_type;

  tick_regs_type r_reg;
  tick_regs_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.count == W'(DIV - 1)) begin
      r_next.count = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.count = r_reg.count + W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule

// *** hdl/deglitch_filter.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Persistence filter on oscillator ticks
// ****************************************************************
// The output rises only after the raw level has been seen on TICKS
// consecutive ticks; it falls on the edge after the raw level drops.
module deglitch_filter #(
  parameter int TICKS = power_seq_pkg::TEMP_TICKS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic raw,
  output logic filtered
);

  localparam int W = $clog2(TICKS + 1);

  typedef struct packed {
    logic [W-1:0] count;
    logic filtered;
  } filt_regs_type;

  filt_regs_type r_reg;
  filt_regs_type r_next;

  always_comb begin
    r_next = r_reg;
    if (!raw) begin
      r_next.count = '0;
      r_next.filtered = 1'b0;
    end else if (tick && r_reg.count != W'(TICKS)) begin
      r_next.count = r_reg.count + W'(1);
      r_next.filtered = (r_reg.count == W'(TICKS - 1));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign filtered = r_reg.filtered;

endmodule

// *** testbench/mcu_model.sv ***
`timescale 1ns/1ps

// ****************************************************************
// Controller model on the shared enable/fault pin
// ****************************************************************
// The pin has a pull-up, so each party can only pull it low. The model never
// drives the wire high, because that would fight the device's own pulldown.
module mcu_model (
  input wire logic enable_drive,
  input wire logic pin_oe_n,
  output logic pin_level
);
  assign pin_level = pin_oe_n & enable_drive;
endmodule

// *** testbench/power_enable_fault_sequencer_tb.sv ***
`timescale 1ns/1ps

`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

// ****************************************************************
// Sequencer testbench
// ****************************************************************
module power_enable_fault_sequencer_tb;
  localparam int EN_T = 4;
  localparam int VIO_T = 8;
  localparam int TEMP_T = 4;
  localparam power_seq_pkg::seq_state_type OFF = power_seq_pkg::SEQ_OFF;
  localparam power_seq_pkg::seq_state_type LAT = power_seq_pkg::SEQ_RUN_LATCHED;
  localparam power_seq_pkg::seq_state_type SA = power_seq_pkg::SEQ_RUN_STANDALONE;
  logic clock = 1'b0;
  logic rst = 1'b1;
  power_seq_pkg::supply_status_type supply = '0;
  logic fault_detect = 1'b0;
  logic temp_warning_raw = 1'b0;
  logic temp_shutdown_raw = 1'b0;
  logic latch_clear = 1'b0;
  logic uv_clear = 1'b0;
  logic enable_drive = 1'b0;
  logic pin_level;
  logic pin_out;
  logic pin_oe_n;
  logic rails_on;
  power_seq_pkg::seq_state_type power_state;
  power_seq_pkg::seq_status_type status;
  int checks = 0;
  int bad_count = 0;
  int seed = 32'h360cedec;
  int n;
  int k;
  logic [6:0] pick;

  always #4 clock = ~clock;

  mcu_model partner (
    .enable_drive(enable_drive),
    .pin_oe_n(pin_oe_n),
    .pin_level(pin_level)
  );

  // Short counts keep the run brief; every expectation uses the same values.
  power_enable_fault_sequencer #(
    .OSC_DIV(1),
    .EN_TICKS(EN_T),
    .VIO_TICKS(VIO_T),
    .TEMP_TICKS(TEMP_T)
  ) dut (
    .clock(clock),
    .rst(rst),
    .supply(supply),
    .fault_detect(fault_detect),
    .temp_warning_raw(temp_warning_raw),
    .temp_shutdown_raw(temp_shutdown_raw),
    .enable_latch_hold_clear(latch_clear),
    .io_supply_uv_fault_clear(uv_clear),
    .enable_fault_pin_in(pin_level),
    .enable_fault_pin_out(pin_out),
    .enable_fault_pin_oe_n(pin_oe_n),
    .rails_on(rails_on),
    .power_state(power_state),
    .status(status)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Power-up is allowed only with enable high, input above lockout and a valid mode.
  function automatic logic exp_start(input logic en, input power_seq_pkg::supply_status_type s);
    return en && s.vin_above_on && !s.vin_below_off && (s.io_supply_high || s.io_supply_grounded);
  endfunction

  task automatic step(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wait_state(input power_seq_pkg::seq_state_type s, input int max);
    n = 0;
    while (power_state !== s && n < max) begin
      step(1);
      n++;
    end
    if (power_state !== s) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, power_state, s);
      end_sim();
    end
  endtask

  task automatic reset_dut();
    rst = 1'b1;
    supply = '0;
    fault_detect = 1'b0;
    enable_drive = 1'b0;
    step(2);
    rst = 1'b0;
  endtask

  task automatic start(input logic serial);
    supply = {1'b1, 1'b0, serial, !serial, 2'b00};
    enable_drive = 1'b1;
    wait_state(serial ? LAT : SA, 10 * EN_T + 20);
    `CHK(n == EN_T + 1, 1'b1)
    `CHK({rails_on, status.enable_latch_hold, status.serial_mode}, {1'b1, serial, serial})
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    step(12);
    rst = 1'b0;
    `CHK({power_state, rails_on, pin_oe_n, status, pin_out}, {OFF, 1'b0, 1'b1, 5'h00, 1'b0})
    // Random levels follow the hand-picked ones; any draw that would start is spoiled.
    for (k = 0; k < 8; k++) begin
      pick = k == 0 ? 7'h48 : k == 1 ? 7'h60 : k == 2 ? 7'h78 : k == 3 ? 7'h28 : 7'($random(seed));
      if (exp_start(pick[6], pick[5:0])) begin
        pick[5] = 1'b0;
      end
      {enable_drive, supply} = pick;
      step(EN_T * 3);
      `CHK(power_state, OFF)
    end
    $display("test start_refused done");

    start(1'b1);
    enable_drive = 1'b0;
    step(5);
    `CHK(power_state, LAT)
    enable_drive = 1'b1;
    supply.io_supply_uv = 1'b1;
    step(1);
    supply.io_supply_uv = 1'b0;
    step(2);
    `CHK({power_state, status.io_supply_uv_fault}, {LAT, 1'b1})
    {supply.io_supply_uv, uv_clear} = 2'b11;
    step(1);
    supply.io_supply_uv = 1'b0;
    `CHK(status.io_supply_uv_fault, 1'b1)
    step(1);
    uv_clear = 1'b0;
    `CHK(status.io_supply_uv_fault, 1'b0)
    for (k = 0; k < 8; k++) begin
      fault_detect = 1'($random(seed));
      step(1);
      `CHK(pin_oe_n, !fault_detect)
    end
    for (k = 0; k < 2; k++) begin
      {temp_shutdown_raw, temp_warning_raw} = 2'(k + 1);
      n = 0;
      while (status[4 - k] !== 1'b1 && n < 50) begin
        step(1);
        n++;
      end
      `CHK({status[4 - k], n == TEMP_T, power_state}, {2'b11, LAT})
      if (n == 50) begin
        end_sim();
      end
      {temp_shutdown_raw, temp_warning_raw} = 2'b00;
      step(2);
      `CHK(status[4 - k], 1'b0)
    end
    fault_detect = 1'b1;
    step(1);
    latch_clear = 1'b1;
    step(1);
    latch_clear = 1'b0;
    `CHK(power_state, power_seq_pkg::SEQ_RUN_UNLATCHED)
    step(1);
    `CHK({power_state, rails_on, pin_oe_n}, {OFF, 1'b0, 1'b1})
    $display("test serial_latched done");

    for (k = 0; k < 2; k++) begin
      reset_dut();
      start(k[0]);
      supply.vin_below_off = 1'b1;
      step(1);
      `CHK({power_state, rails_on}, {OFF, 1'b0})
    end
    $display("test input_lockout done");

    reset_dut();
    start(1'b0);
    latch_clear = 1'b1;
    supply.io_supply_sd = 1'b1;
    step(VIO_T * 3);
    latch_clear = 1'b0;
    `CHK(power_state, SA)
    supply.io_supply_sd = 1'b0;
    enable_drive = 1'b0;
    step(1);
    `CHK({power_state, rails_on}, {OFF, 1'b0})
    $display("test standalone done");

    // Drops land inside the deglitch window at a random tick.
    for (k = 0; k < 4; k++) begin
      reset_dut();
      supply = 6'h28;
      enable_drive = 1'b1;
      wait_state(power_seq_pkg::SEQ_POWER_UP, 4);
      step($unsigned($random(seed)) % (EN_T - 1));
      enable_drive = 1'b0;
      step(1);
      `CHK({power_state, rails_on}, {OFF, 1'b0})
    end
    $display("test enable_abort done");

    reset_dut();
    start(1'b1);
    fault_detect = 1'b1;
    supply.io_supply_sd = 1'b1;
    step(VIO_T - 2);
    supply.io_supply_sd = 1'b0;
    step(4);
    `CHK({power_state, pin_oe_n}, {LAT, 1'b0})
    supply.io_supply_sd = 1'b1;
    wait_state(OFF, VIO_T * 3 + 10);
    `CHK(n >= VIO_T, 1'b1)
    `CHK({pin_oe_n, status.enable_latch_hold, rails_on}, 3'b100)
    supply.io_supply_sd = 1'b0;
    fault_detect = 1'b0;
    wait_state(LAT, 10 * EN_T + 20);
    `CHK(rails_on, 1'b1)
    latch_clear = 1'b1;
    step(1);
    latch_clear = 1'b0;
    step(3);
    `CHK({power_state, rails_on}, {power_seq_pkg::SEQ_RUN_UNLATCHED, 1'b1})
    enable_drive = 1'b0;
    step(1);
    `CHK({power_state, rails_on}, {OFF, 1'b0})
    $display("test io_shutdown done");
    end_sim();
  end
endmodule
